// ===== core/pic_cfg.svh
// offsets, reset values, limits and timing of the pi loop controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
// register byte offsets
`define PIC_OFF_CTRL 8'h00
`define PIC_OFF_LOOP_GAIN 8'h04
`define PIC_OFF_INT_PERIOD 8'h08
`define PIC_OFF_SETPOINT 8'h0C
`define PIC_OFF_PV_GAIN 8'h10
`define PIC_OFF_PV_OFFSET 8'h14
`define PIC_OFF_PV_MIN 8'h18
`define PIC_OFF_PV_MAX 8'h1C
`define PIC_OFF_PV 8'h20
`define PIC_OFF_MV 8'h24
`define PIC_OFF_INTEG 8'h28
`define PIC_OFF_COUNT 8'h2C
// ctrl field positions
`define PIC_CTRL_EN 0
`define PIC_CTRL_DIR_NEG 1
`define PIC_CTRL_SP_EXT 2
// reset values
`define PIC_RST_LOOP_GAIN 14'h0064
`define PIC_RST_INT_PERIOD 13'h003C
`define PIC_RST_PV_GAIN 7'h0A
`define PIC_RST_PV_MIN (-16'sd10000)
`define PIC_RST_PV_MAX (16'sd20000)
// limits
`define PIC_RANGE_LO (-32'sd10000)
`define PIC_RANGE_HI (32'sd20000)
`define PIC_MV_MAX 32'sd1000
`define PIC_KC_MAX 32'sd9999
`define PIC_KC_SCALE 100
`define PIC_KI_ZERO 14'h0064
`define PIC_TI_MIN 32'sd1
`define PIC_TI_MAX 32'sd5999
`define PIC_GAIN_MAX 32'sd100
`define PIC_GAIN_SCALE 32'sd10
`define PIC_FRAC 8
`define PIC_DIV_BITS 40
// timing
`define PIC_SAMPLE_MS 500
`define PIC_CLK_KHZ 125000
`define PIC_SAMPLE_CYC (`PIC_SAMPLE_MS * `PIC_CLK_KHZ)
`define PIC_DEN_FACTOR ((`PIC_KC_SCALE * 1000) / `PIC_SAMPLE_MS)
`endif

// ===== core/pic_pkg.sv
// types of the pi loop controller
package pic_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_PV, ST_ERR, ST_DIV, ST_OUT} pic_state_e;
   typedef struct packed {
      logic en;
      logic dir_neg;
      logic sp_ext;
      logic [13:0] loop_gain;
      logic [12:0] int_period;
      logic signed [15:0] setpoint;
      logic [6:0] pv_gain;
      logic signed [15:0] pv_offset;
      logic signed [15:0] pv_min;
      logic signed [15:0] pv_max;
   } pic_cfg_s;
endpackage : pic_pkg

// ===== core/pic_loop_controller.sv
// sampled pi loop controller with apb register access
`timescale 1ns/10ps
`include "pic_cfg.svh"
module pic_loop_controller
#(
   parameter int SAMPLE_CYCLES = `PIC_SAMPLE_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // process side
   input wire logic signed [15:0] ain_value,
   input wire logic signed [15:0] setpoint_ext,
   output logic [9:0] mv_out,
   output logic sample_done
);
   import pic_pkg::*;

   function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   pic_cfg_s cfg_reg;
   pic_state_e st_reg;
   logic [25:0] tick_cnt_reg;
   logic [31:0] count_reg;
   logic signed [15:0] pv_reg;
   logic signed [17:0] err_reg;
   logic signed [31:0] prop_reg;
   logic signed [31:0] integ_reg;
   logic [9:0] mv_reg;
   logic neg_reg;
   logic done_reg;
   logic [23:0] den_reg;
   logic [39:0] num_reg;
   logic [24:0] rem_reg;
   logic [39:0] quo_reg;
   logic [5:0] div_cnt_reg;
   logic [31:0] prdata_reg;

   // apb decode
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic [7:0] off = paddr[7:0];
   wire logic hi_zero = (paddr[31:8] == 24'h000000);
   wire logic is_rw = hi_zero & (off <= `PIC_OFF_PV_MAX) & (off[1:0] == 2'b00);
   wire logic is_ro = hi_zero & (off >= `PIC_OFF_PV) & (off <= `PIC_OFF_COUNT)
                      & (off[1:0] == 2'b00);
   wire logic wr = access & pwrite & is_rw;
   wire logic signed [31:0] wd = $signed(pwdata);
   // out-of-range writes saturate so the datapath never sees illegal settings
   wire logic [13:0] kc_w = 14'(clamp(wd, 32'sd0, `PIC_KC_MAX));
   wire logic [12:0] ti_w = 13'(clamp(wd, `PIC_TI_MIN, `PIC_TI_MAX));
   wire logic [6:0] g_w = 7'(clamp(wd, 32'sd0, `PIC_GAIN_MAX));
   wire logic signed [15:0] rng_w = 16'(clamp(wd, `PIC_RANGE_LO, `PIC_RANGE_HI));

   assign pready = 1'b1;
   assign pslverr = access & ~(pwrite ? is_rw : (is_rw | is_ro));
   assign prdata = prdata_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg <= '{en: 1'b0, dir_neg: 1'b0, sp_ext: 1'b0,
                      loop_gain: `PIC_RST_LOOP_GAIN, int_period: `PIC_RST_INT_PERIOD,
                      setpoint: 16'sh0000, pv_gain: `PIC_RST_PV_GAIN,
                      pv_offset: 16'sh0000, pv_min: `PIC_RST_PV_MIN,
                      pv_max: `PIC_RST_PV_MAX};
      end
      else if (wr)
      begin
         unique case (off)
            `PIC_OFF_CTRL:
            begin
               cfg_reg.en <= pwdata[`PIC_CTRL_EN];
               cfg_reg.dir_neg <= pwdata[`PIC_CTRL_DIR_NEG];
               cfg_reg.sp_ext <= pwdata[`PIC_CTRL_SP_EXT];
            end
            `PIC_OFF_LOOP_GAIN: cfg_reg.loop_gain <= kc_w;
            `PIC_OFF_INT_PERIOD: cfg_reg.int_period <= ti_w;
            `PIC_OFF_SETPOINT: cfg_reg.setpoint <= rng_w;
            `PIC_OFF_PV_GAIN: cfg_reg.pv_gain <= g_w;
            `PIC_OFF_PV_OFFSET: cfg_reg.pv_offset <= rng_w;
            `PIC_OFF_PV_MIN: cfg_reg.pv_min <= rng_w;
            `PIC_OFF_PV_MAX: cfg_reg.pv_max <= rng_w;
            default: ;
         endcase
      end
   end

   // read mux, captured in setup so access completes with zero wait
   wire logic [31:0] rd_mux =
      (off == `PIC_OFF_CTRL) ? {29'h0, cfg_reg.sp_ext, cfg_reg.dir_neg, cfg_reg.en} :
      (off == `PIC_OFF_LOOP_GAIN) ? {18'h0, cfg_reg.loop_gain} :
      (off == `PIC_OFF_INT_PERIOD) ? {19'h0, cfg_reg.int_period} :
      (off == `PIC_OFF_SETPOINT) ? 32'(cfg_reg.setpoint) :
      (off == `PIC_OFF_PV_GAIN) ? {25'h0, cfg_reg.pv_gain} :
      (off == `PIC_OFF_PV_OFFSET) ? 32'(cfg_reg.pv_offset) :
      (off == `PIC_OFF_PV_MIN) ? 32'(cfg_reg.pv_min) :
      (off == `PIC_OFF_PV_MAX) ? 32'(cfg_reg.pv_max) :
      (off == `PIC_OFF_PV) ? 32'(pv_reg) :
      (off == `PIC_OFF_MV) ? {22'h0, mv_reg} :
      (off == `PIC_OFF_INTEG) ? 32'(integ_reg >>> `PIC_FRAC) :
      (off == `PIC_OFF_COUNT) ? count_reg : 32'h00000000;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prdata_reg <= 32'h00000000;
      else if (setup)
         prdata_reg <= (hi_zero & ~pwrite) ? rd_mux : 32'h00000000;
   end

   // sample timer
   wire logic tick = cfg_reg.en & (tick_cnt_reg == 26'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tick_cnt_reg <= 26'h0000000;
      else if (~cfg_reg.en | tick)
         tick_cnt_reg <= 26'h0000000;
      else
         tick_cnt_reg <= tick_cnt_reg + 26'h0000001;
   end

   // process value
   wire logic signed [23:0] pv_prod = ain_value * $signed({1'b0, cfg_reg.pv_gain});
   wire logic signed [31:0] pv_raw = 32'(pv_prod) / `PIC_GAIN_SCALE
                                     + 32'(cfg_reg.pv_offset);
   // crossed limits: below min gives min, otherwise max
   wire logic signed [15:0] pv_w = 16'(clamp(pv_raw, 32'(cfg_reg.pv_min),
                                       32'(cfg_reg.pv_max)));

   // error and gains
   wire logic signed [15:0] sp = cfg_reg.sp_ext ? setpoint_ext : cfg_reg.setpoint;
   wire logic signed [17:0] e_fwd = 18'(sp) - 18'(pv_reg);
   wire logic signed [17:0] e_w = cfg_reg.dir_neg ? -e_fwd : e_fwd;
   wire logic kc_zero = (cfg_reg.loop_gain == 14'h0000);
   wire logic [13:0] ki = kc_zero ? `PIC_KI_ZERO : cfg_reg.loop_gain;
   // both factors widened first so the product cannot wrap at 18 bits
   wire logic signed [31:0] p_w = ($signed({18'h00000, cfg_reg.loop_gain}) * 32'(e_w))
                                  / `PIC_KC_SCALE;
   wire logic [17:0] abs_e = e_w[17] ? 18'(-e_w) : 18'(e_w);
   // integral increment kept with fraction bits so small gains still integrate
   wire logic [39:0] num_w = (40'(ki) * 40'(abs_e)) << `PIC_FRAC;
   wire logic [23:0] den_w = 24'(32'(cfg_reg.int_period) * `PIC_DEN_FACTOR);

   // restoring divider, one quotient bit per clock
   wire logic [24:0] rem_sh = {rem_reg[23:0], num_reg[39]};
   wire logic div_ge = rem_sh >= {1'b0, den_reg};
   wire logic [24:0] rem_nx = div_ge ? (rem_sh - {1'b0, den_reg}) : rem_sh;

   // output stage
   wire logic ti_off = (32'(cfg_reg.int_period) == `PIC_TI_MAX);
   wire logic signed [31:0] incr = ti_off ? 32'sd0
                                   : (neg_reg ? -$signed(quo_reg[31:0])
                                              : $signed(quo_reg[31:0]));
   // integral sum held within output range so it cannot wind up
   wire logic signed [31:0] integ_w = clamp(integ_reg + incr, 32'sd0,
                                            `PIC_MV_MAX <<< `PIC_FRAC);
   wire logic signed [31:0] mv_w = clamp(prop_reg + (integ_w >>> `PIC_FRAC),
                                         32'sd0, `PIC_MV_MAX);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_reg <= ST_IDLE;
      else
      begin
         unique case (st_reg)
            ST_IDLE: if (tick) st_reg <= ST_PV;
            ST_PV: st_reg <= ST_ERR;
            ST_ERR: st_reg <= ST_DIV;
            ST_DIV: if (div_cnt_reg == 6'h00) st_reg <= ST_OUT;
            ST_OUT: st_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pv_reg <= 16'sh0000;
         err_reg <= 18'sh00000;
         prop_reg <= 32'sh00000000;
         neg_reg <= 1'b0;
         den_reg <= 24'h000000;
      end
      else if (st_reg == ST_PV)
         pv_reg <= pv_w;
      else if (st_reg == ST_ERR)
      begin
         err_reg <= e_w;
         prop_reg <= kc_zero ? 32'sh00000000 : p_w;
         neg_reg <= e_w[17];
         den_reg <= den_w;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         num_reg <= 40'h0000000000;
         rem_reg <= 25'h0000000;
         quo_reg <= 40'h0000000000;
         div_cnt_reg <= 6'h00;
      end
      else if (st_reg == ST_ERR)
      begin
         num_reg <= num_w;
         rem_reg <= 25'h0000000;
         quo_reg <= 40'h0000000000;
         div_cnt_reg <= 6'(`PIC_DIV_BITS - 1);
      end
      else if (st_reg == ST_DIV)
      begin
         num_reg <= {num_reg[38:0], 1'b0};
         rem_reg <= rem_nx;
         quo_reg <= {quo_reg[38:0], div_ge};
         div_cnt_reg <= div_cnt_reg - 6'h01;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         integ_reg <= 32'sh00000000;
         mv_reg <= 10'h000;
         count_reg <= 32'h00000000;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= (st_reg == ST_OUT);
         if (st_reg == ST_OUT)
         begin
            integ_reg <= integ_w;
            mv_reg <= 10'(mv_w);
            count_reg <= count_reg + 32'h00000001;
         end
      end
   end

   assign mv_out = mv_reg;
   assign sample_done = done_reg;

   AST_MV_RANGE: assert property (@(posedge clk) disable iff (rst)
      mv_out <= 10'(`PIC_MV_MAX)) else $error("output above limit");
   AST_KC_RANGE: assert property (@(posedge clk) disable iff (rst)
      32'(cfg_reg.loop_gain) <= `PIC_KC_MAX) else $error("loop gain out of range");
   AST_TI_RANGE: assert property (@(posedge clk) disable iff (rst)
      (32'(cfg_reg.int_period) >= `PIC_TI_MIN) && (32'(cfg_reg.int_period) <= `PIC_TI_MAX))
      else $error("integral period out of range");
   AST_PV_CLAMP: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_PV) && (cfg_reg.pv_min <= cfg_reg.pv_max) |=>
      (pv_reg >= cfg_reg.pv_min) && (pv_reg <= cfg_reg.pv_max))
      else $error("process value outside limits");
   AST_SAMPLE_SEQ: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_IDLE) && tick |=> (st_reg == ST_PV) ##1 (st_reg == ST_ERR)
      ##41 (st_reg == ST_OUT) ##1 sample_done) else $error("sample sequence broken");
   AST_KC_ZERO: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_ERR) && kc_zero |=> (prop_reg == 32'sd0))
      else $error("p part active with zero gain");
   AST_DIR_POS: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_ERR) && !cfg_reg.dir_neg && (sp > pv_reg) |=> (err_reg > 18'sd0))
      else $error("positive sense error sign wrong");
   AST_DIR_NEG: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_ERR) && cfg_reg.dir_neg && (sp > pv_reg) |=> (err_reg < 18'sd0))
      else $error("negative sense error sign wrong");
   AST_I_OFF: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_OUT) && ti_off && $stable(integ_reg) |=> $stable(integ_reg))
      else $error("integral moved while switched off");
   AST_ERR_DEF: assert property (@(posedge clk) disable iff (rst)
      (st_reg == ST_ERR) && !cfg_reg.dir_neg |=> (err_reg == 18'(sp) - 18'($past(pv_reg))))
      else $error("error is not setpoint minus process value");
endmodule : pic_loop_controller

// ===== testbench/pic_ain_model.sv
// analog input source feeding the process value of the loop controller
`timescale 1ns/10ps
module pic_ain_model
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // requested level and settling mode
   input wire logic signed [15:0] level,
   input wire logic slow,
   // value seen by the controller
   output logic signed [15:0] ain_value
);
   logic signed [15:0] diff;
   logic near;
   assign diff = level - ain_value;
   assign near = (diff < 16'sh0100) && (diff > -16'sh0100);
   // slow mode ramps like a filtered converter, so a stale sample would show
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ain_value <= 16'sh0000;
      else if (!slow || near)
         ain_value <= level;
      else if (diff > 16'sh0000)
         ain_value <= ain_value + 16'sh0100;
      else
         ain_value <= ain_value - 16'sh0100;
   end
endmodule : pic_ain_model

// ===== testbench/pi_loop_controller_test.sv
// self-checking bench of the pi loop controller
`timescale 1ns/10ps
`include "pic_cfg.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin failures++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module pi_loop_controller_test;
   import pic_pkg::*;
   localparam int SC = 100;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, sample_done, slow, err, dneg, sext;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic signed [15:0] ain_value, setpoint_ext, level;
   logic [9:0] mv_out;
   logic [31:0] seed = 32'hD25E;
   int failures = 0;
   int checks_done = 0;
   int gap = -1;
   int integ = 0;
   int kc, ti, sp, g, off, lo, hi, pv, e, p, mv, n;
   int sat_a[5] = '{'h04, 'h08, 'h10, 'h0C, 'h1C};
   int sat_d[5] = '{20000, 0, 200, -30000, 30000};
   logic [31:0] sat_x[5] = '{32'h270F, 32'h1, 32'h64, 32'hFFFFD8F0, 32'h4E20};

   pic_loop_controller #(.SAMPLE_CYCLES(SC)) u_pic_loop_controller (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ain_value(ain_value),
      .setpoint_ext(setpoint_ext), .mv_out(mv_out), .sample_done(sample_done));
   pic_ain_model u_pic_ain_model (.clk(clk), .rst(rst), .level(level), .slow(slow),
      .ain_value(ain_value));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic int rr(int a, int b);
      return a + int'(xs() % 32'(b - a + 1));
   endfunction : rr

   // lower bound tested first: crossed limits give min below it, max above
   function automatic int clampi(int v, int a, int b);
      if (v < a)
         return a;
      if (v > b)
         return b;
      return v;
   endfunction : clampi

   function automatic logic [31:0] rst_val(int a);
      case (a)
         `PIC_OFF_LOOP_GAIN: return 32'h64;
         `PIC_OFF_INT_PERIOD: return 32'h3C;
         `PIC_OFF_PV_GAIN: return 32'hA;
         `PIC_OFF_PV_MIN: return 32'hFFFFD8F0;
         `PIC_OFF_PV_MAX: return 32'h4E20;
         default: return 32'h0;
      endcase
   endfunction : rst_val

   task automatic end_sim();
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   // one apb transfer, idle cycle after so strobes never change twice in a step
   task automatic apb(input logic w, input int a, input int d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= 32'(a);
      pwdata <= 32'(d);
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      k = 0;
      while (pready !== 1'b1 && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 50)
         failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // sampling period between consecutive results
   always @(posedge clk)
   begin
      if (rst)
         gap = -1;
      else if (sample_done === 1'b1)
      begin
         if (gap >= 0)
            `CHK("sample gap", SC, gap)
         gap = 1;
      end
      else if (gap >= 0)
         gap++;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, slow} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      setpoint_ext = 16'sh0000;
      level = 16'sh0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a <= 'h2C; a += 4)
      begin
         apb(1'b0, a, 0);
         `CHK("reset value", rst_val(a), rd)
      end
      apb(1'b0, 'h30, 0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, `PIC_OFF_MV, 5);
      `CHK("read-only err", 1'b1, err)
      for (int s = 0; s < 5; s++)
      begin
         apb(1'b1, sat_a[s], sat_d[s]);
         apb(1'b0, sat_a[s], 0);
         `CHK("saturated write", sat_x[s], rd)
      end
      for (int i = 0; i < 14; i++)
      begin
         // first three: integral windup, integral off, full gain
         kc = (i == 0) ? 0 : (i == 2) ? 9999 : rr(0, 9999);
         ti = (i == 0) ? 1 : (i == 1) ? 5999 : rr(1, 5999);
         sp = (i == 0) ? 20000 : rr(-10000, 20000);
         g = rr(0, 100);
         off = rr(-10000, 20000);
         lo = rr(-10000, 20000);
         hi = rr(-10000, 20000);
         dneg = (i > 2) && (rr(0, 1) == 1);
         sext = (i > 2) && (rr(0, 1) == 1);
         level <= 16'(rr(-2000, 2000));
         slow <= 1'(rr(0, 1));
         setpoint_ext <= 16'(rr(-10000, 20000));
         apb(1'b1, `PIC_OFF_LOOP_GAIN, kc);
         apb(1'b1, `PIC_OFF_INT_PERIOD, ti);
         apb(1'b1, `PIC_OFF_SETPOINT, sp);
         apb(1'b1, `PIC_OFF_PV_GAIN, g);
         apb(1'b1, `PIC_OFF_PV_OFFSET, off);
         apb(1'b1, `PIC_OFF_PV_MIN, lo);
         apb(1'b1, `PIC_OFF_PV_MAX, hi);
         apb(1'b1, `PIC_OFF_CTRL, {sext, dneg, 1'b1});
         n = 0;
         while (sample_done !== 1'b1 && n < 400)
         begin
            @(negedge clk);
            n++;
         end
         if (n >= 400)
            failures++;
         pv = clampi(int'(level) * g / 10 + off, lo, hi);
         e = (sext ? int'(setpoint_ext) : sp) - pv;
         e = dneg ? -e : e;
         p = (kc == 0) ? 0 : kc * e / 100;
         if (ti != 5999)
            integ = clampi(int'(longint'(kc == 0 ? 100 : kc) * e * 256 / (200 * ti)) + integ,
               0, 256000);
         mv = clampi(p + (integ >>> 8), 0, 1000);
         `CHK("mv_out", 10'(mv), mv_out)
         @(posedge clk);
         apb(1'b0, `PIC_OFF_PV, 0);
         `CHK("process value", 32'(pv), rd)
         apb(1'b0, `PIC_OFF_INTEG, 0);
         `CHK("integral sum", 32'(integ >>> 8), rd)
         apb(1'b0, `PIC_OFF_COUNT, 0);
         `CHK("sample count", 32'(i + 1), rd)
      end
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("mv after reset", 10'h0, mv_out)
      @(posedge clk);
      apb(1'b0, `PIC_OFF_INTEG, 0);
      `CHK("integral after reset", 32'h0, rd)
      end_sim();
   end
endmodule : pi_loop_controller_test
